// ===== src/dss_sequencer.sv
// Notes on behaviour
// - Emergency stops and trip end in inhibit.
// - Leave inhibit only after on seen low.
// - Off holds until stops clear, remote set.
// - Ready-to-on: flux on, pulses inhibited.
// - Run enables controllers; advance when ready.
// - Operation enabled tracks controller references.
// - Ramp output withdrawn clamps ramp to zero.
// - Ramp acceleration runs or holds.
// - Operating status releases ramp input.
// - On removed: ramp stop, speed zero, off.
// - Coast stop removes voltage, then inhibit.
// - Quick stop decelerates, then inhibit.
// - Trip holds until reset rising edge.
// - Bit 11 starts and stops by ramp.
// - Run permit low coasts the drive.
module dss_sequencer
  import dss_pkg::*;
(
  input wire logic clock_i, // 125 MHz clock
  input wire logic rst_b_i, // Sync reset, active low
  input wire logic [dss_pkg::CW_WIDTH-1:0] cw_i, // Command word block
  input wire logic fault_i, // Fault indication
  input wire logic ctrl_ready_i, // All internal controllers ready
  input wire logic zero_speed_i, // Speed has reached zero
  output logic [3:0] state_o, // Encoded state
  output logic flux_en_o, // Flux enable
  output logic pulses_en_o, // Stator switching pulses enable
  output logic ctrl_en_o, // Internal controllers enable
  output logic ref_track_o, // Following external references
  output logic ramp_clamp_o, // Ramp output forced to zero
  output logic ramp_hold_o, // Ramp frozen
  output logic ramp_in_rel_o, // Ramp input released
  output logic ramp_stop_o, // Decelerating on stop ramp
  output logic quick_stop_active_o, // Emergency deceleration
  output logic coast_stop_active_o, // Output voltage removed
  output logic fault_latched_o // Fault_latched
);
  import dss_pkg::*;

  dss_state_t state_q, state_d;
  logic rst_cmd_q, rst_cmd_d;
  logic flux_d, pulses_d, ctrl_d, track_d, clamp_d, hold_d, inrel_d;

  // Decoded commands; bits 1 and 2 are active low
  logic on_cmd, coast_req, qstop_req, run_permit, remote, reset_rise;
  assign on_cmd = cw_i[CW_ON_BIT] | cw_i[CW_NRAMP_START_BIT];
  assign coast_req = ~cw_i[CW_NO_COAST_BIT];
  assign qstop_req = ~cw_i[CW_NO_QSTOP_BIT];
  assign run_permit = cw_i[CW_RUN_BIT];
  assign remote = cw_i[CW_REMOTE_BIT];
  assign reset_rise = cw_i[CW_RESET_BIT] & ~rst_cmd_q;

  // Next state; fault first, then coast, quick stop, ramp stop
  always_comb begin
    state_d = state_q;
    rst_cmd_d = cw_i[CW_RESET_BIT];
    if (fault_i && state_q != DSS_FAULT) begin
      state_d = DSS_FAULT;
    end else begin
      unique case (state_q)
        DSS_ON_INHIBIT: begin
          if (!on_cmd) state_d = DSS_OFF;
        end
        DSS_OFF: begin
          if (!coast_req && !qstop_req && remote) state_d = DSS_RDY_ON;
        end
        DSS_FAULT: begin
          if (reset_rise && !fault_i) state_d = DSS_ON_INHIBIT;
        end
        DSS_COAST_STOP: state_d = DSS_ON_INHIBIT;
        DSS_QUICK_STOP: begin
          if (coast_req) state_d = DSS_COAST_STOP;
          else if (zero_speed_i) state_d = DSS_ON_INHIBIT;
        end
        default: begin
          // Operating states share the stop priority
          if (coast_req) begin
            state_d = DSS_COAST_STOP;
          end else if (qstop_req) begin
            state_d = DSS_QUICK_STOP;
          end else if (state_q == DSS_RAMP_STOP) begin
            if (zero_speed_i) state_d = DSS_OFF;
          end else if (!on_cmd) begin
            state_d = DSS_RAMP_STOP;
          end else if (!run_permit) begin
            state_d = DSS_RDY_ON; // coast to ready, no ramp
          end else if (state_q == DSS_RDY_ON) begin
            state_d = DSS_RDY_RUN;
          end else if (state_q == DSS_RDY_RUN && ctrl_ready_i) begin
            state_d = DSS_RDY_REF;
          end
        end
      endcase
    end
  end

  // Outputs follow the next state so they change with the transition
  always_comb begin
    flux_d = state_d inside {DSS_RDY_ON, DSS_RDY_RUN, DSS_RDY_REF,
                             DSS_RAMP_STOP, DSS_QUICK_STOP};
    pulses_d = state_d inside {DSS_RDY_REF, DSS_RAMP_STOP, DSS_QUICK_STOP};
    ctrl_d = state_d inside {DSS_RDY_RUN, DSS_RDY_REF, DSS_RAMP_STOP,
                             DSS_QUICK_STOP};
    track_d = (state_d == DSS_RDY_REF);
    // Stops force ramp output to zero so the drive decelerates
    clamp_d = !track_d || !cw_i[CW_RAMP_OUT_BIT];
    hold_d = track_d && cw_i[CW_RAMP_OUT_BIT] && !cw_i[CW_RAMP_ACC_BIT];
    inrel_d = track_d && cw_i[CW_RAMP_OUT_BIT] && cw_i[CW_RAMP_ACC_BIT]
              && cw_i[CW_RAMP_IN_BIT];
  end

  // Registers; outputs come straight from flops
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      state_q <= DSS_RESET_STATE;
      rst_cmd_q <= 1'b0;
      state_o <= DSS_STATE_RESET_CODE;
      flux_en_o <= 1'b0;
      pulses_en_o <= 1'b0;
      ctrl_en_o <= 1'b0;
      ref_track_o <= 1'b0;
      ramp_clamp_o <= 1'b1;
      ramp_hold_o <= 1'b0;
      ramp_in_rel_o <= 1'b0;
      ramp_stop_o <= 1'b0;
      quick_stop_active_o <= 1'b0;
      coast_stop_active_o <= 1'b0;
      fault_latched_o <= 1'b0;
    end else begin
      state_q <= state_d;
      rst_cmd_q <= rst_cmd_d;
      state_o <= state_d;
      flux_en_o <= flux_d;
      pulses_en_o <= pulses_d;
      ctrl_en_o <= ctrl_d;
      ref_track_o <= track_d;
      ramp_clamp_o <= clamp_d;
      ramp_hold_o <= hold_d;
      ramp_in_rel_o <= inrel_d;
      ramp_stop_o <= (state_d == DSS_RAMP_STOP);
      quick_stop_active_o <= (state_d == DSS_QUICK_STOP);
      coast_stop_active_o <= (state_d == DSS_COAST_STOP);
      fault_latched_o <= (state_d == DSS_FAULT);
    end
  end

  // Checks
  AST_INHIBIT_NEEDS_ON_LOW: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    (state_q == DSS_ON_INHIBIT && !fault_i && on_cmd) |=> state_q == DSS_ON_INHIBIT)
    else $error("inhibit left with on command high");
  AST_OFF_TO_RDY: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    (state_q == DSS_OFF && !fault_i && !coast_req && !qstop_req && remote)
    |=> state_q == DSS_RDY_ON) else $error("off did not advance");
  AST_OFF_HOLD: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    (state_q == DSS_OFF && !fault_i && (coast_req || qstop_req)) |=> state_q == DSS_OFF)
    else $error("off left with stop active");
  AST_FLUX_NO_PULSE: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    state_o == DSS_RDY_ON |-> flux_en_o && !pulses_en_o)
    else $error("ready-to-on outputs wrong");
  AST_REF_NEEDS_READY: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    (state_q == DSS_RDY_REF && $past(state_q) == DSS_RDY_RUN) |-> $past(ctrl_ready_i))
    else $error("enabled without ready");
  AST_CLAMP: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    (state_d == DSS_RDY_REF && !cw_i[CW_RAMP_OUT_BIT]) |=> ramp_clamp_o && ctrl_en_o)
    else $error("ramp not clamped");
  AST_COAST_PRIO: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    (state_q == DSS_RDY_REF && !fault_i && coast_req && qstop_req)
    |=> state_q == DSS_COAST_STOP ##1 state_q == DSS_ON_INHIBIT)
    else $error("coast priority lost");
  AST_COAST_NO_PULSE: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    coast_stop_active_o |-> !pulses_en_o && !flux_en_o)
    else $error("voltage during coast");
  AST_FAULT_HOLD: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    (state_q == DSS_FAULT && !reset_rise) |=> state_q == DSS_FAULT)
    else $error("fault left without reset edge");
  AST_STATE_OUT: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    ##1 state_o == state_q) else $error("state code stale");

  // Start-up path; a lingering on command must never restart the drive
  AST_INHIBIT_TO_OFF: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    (state_q == DSS_ON_INHIBIT && !fault_i && !on_cmd) |=> state_q == DSS_OFF)
    else $error("inhibit did not move to off");
  AST_OFF_NEEDS_REMOTE: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    (state_q == DSS_OFF && !fault_i && !remote) |=> state_q == DSS_OFF)
    else $error("off left without remote permission");
  AST_RDY_ON_TO_RUN: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    (state_q == DSS_RDY_ON && !fault_i && !coast_req && !qstop_req && on_cmd && run_permit)
    |=> state_q == DSS_RDY_RUN) else $error("run command not taken");
  AST_RDY_ON_NO_RUN: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    (state_q == DSS_RDY_ON && !fault_i && !coast_req && !qstop_req && on_cmd && !run_permit)
    |=> state_q == DSS_RDY_ON) else $error("ready left without run permit");
  AST_RUN_WAITS_READY: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    (state_q == DSS_RDY_RUN && !fault_i && !coast_req && !qstop_req && on_cmd
     && run_permit && !ctrl_ready_i) |=> state_q == DSS_RDY_RUN)
    else $error("operation enabled before controllers ready");
  AST_START_BY_BIT11: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    (state_q == DSS_RDY_ON && !fault_i && !coast_req && !qstop_req && !cw_i[CW_ON_BIT]
     && cw_i[CW_NRAMP_START_BIT] && run_permit) |=> state_q == DSS_RDY_RUN)
    else $error("normal ramp start ignored");

  // Stops; priority is checked from every operating state
  AST_OPER_COAST: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    (state_q inside {DSS_RDY_ON, DSS_RDY_RUN, DSS_RDY_REF, DSS_RAMP_STOP} && !fault_i
     && coast_req) |=> state_q == DSS_COAST_STOP)
    else $error("coast stop not entered");
  AST_OPER_QSTOP: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    (state_q inside {DSS_RDY_ON, DSS_RDY_RUN, DSS_RDY_REF, DSS_RAMP_STOP} && !fault_i
     && !coast_req && qstop_req) |=> state_q == DSS_QUICK_STOP)
    else $error("quick stop not entered");
  AST_ON_LOW_RAMPS: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    (state_q inside {DSS_RDY_ON, DSS_RDY_RUN, DSS_RDY_REF} && !fault_i && !coast_req
     && !qstop_req && !on_cmd) |=> state_q == DSS_RAMP_STOP)
    else $error("ramp stop not entered");
  AST_RUN_DROP: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    (state_q inside {DSS_RDY_RUN, DSS_RDY_REF} && !fault_i && !coast_req && !qstop_req
     && on_cmd && !run_permit) |=> state_q == DSS_RDY_ON)
    else $error("run permit drop not taken");
  AST_RAMP_STOP_WAIT: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    (state_q == DSS_RAMP_STOP && !fault_i && !coast_req && !qstop_req && !zero_speed_i)
    |=> state_q == DSS_RAMP_STOP) else $error("ramp stop left above zero speed");
  AST_RAMP_STOP_DONE: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    (state_q == DSS_RAMP_STOP && !fault_i && !coast_req && !qstop_req && zero_speed_i)
    |=> state_q == DSS_OFF) else $error("ramp stop did not end in off");
  AST_COAST_TO_INHIBIT: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    (state_q == DSS_COAST_STOP && !fault_i) |=> state_q == DSS_ON_INHIBIT)
    else $error("coast stop did not end in inhibit");
  AST_QSTOP_TO_COAST: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    (state_q == DSS_QUICK_STOP && !fault_i && coast_req) |=> state_q == DSS_COAST_STOP)
    else $error("coast did not override quick stop");
  AST_QSTOP_WAIT: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    (state_q == DSS_QUICK_STOP && !fault_i && !coast_req && !zero_speed_i)
    |=> state_q == DSS_QUICK_STOP) else $error("quick stop left above zero speed");
  AST_QSTOP_DONE: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    (state_q == DSS_QUICK_STOP && !fault_i && !coast_req && zero_speed_i)
    |=> state_q == DSS_ON_INHIBIT) else $error("quick stop did not end in inhibit");

  // Faults win over every command
  AST_FAULT_ENTRY: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    fault_i |=> state_q == DSS_FAULT)
    else $error("fault not latched");
  AST_FAULT_EXIT: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    (state_q == DSS_FAULT && reset_rise && !fault_i) |=> state_q == DSS_ON_INHIBIT)
    else $error("reset edge did not clear fault");

  // Output levels; all come from the same next state, so they agree every cycle
  AST_IDLE_NO_DRIVE: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    (state_q inside {DSS_ON_INHIBIT, DSS_OFF, DSS_COAST_STOP, DSS_FAULT})
    |-> !flux_en_o && !pulses_en_o && !ctrl_en_o) else $error("drive active while idle");
  AST_PULSES_NEED_CTRL: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    pulses_en_o |-> ctrl_en_o && flux_en_o)
    else $error("pulses without controllers");
  AST_QSTOP_KEEPS_CTRL: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    quick_stop_active_o |-> ctrl_en_o && pulses_en_o)
    else $error("quick stop lost control");
  AST_TRACK_ONLY_REF: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    ref_track_o == (state_q == DSS_RDY_REF))
    else $error("reference tracking outside operation");
  AST_RAMP_HOLD: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    (state_d == DSS_RDY_REF && cw_i[CW_RAMP_OUT_BIT] && !cw_i[CW_RAMP_ACC_BIT])
    |=> ramp_hold_o && !ramp_clamp_o) else $error("ramp not held");
  AST_IN_RELEASE: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    (state_d == DSS_RDY_REF && cw_i[CW_RAMP_OUT_BIT] && cw_i[CW_RAMP_ACC_BIT]
     && cw_i[CW_RAMP_IN_BIT]) |=> ramp_in_rel_o && !ramp_hold_o)
    else $error("ramp input not released");
  AST_NO_RELEASE_IDLE: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    !ref_track_o |-> ramp_clamp_o && !ramp_in_rel_o && !ramp_hold_o)
    else $error("ramp active outside operation");
  AST_RAMP_FLAG: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    ramp_stop_o == (state_q == DSS_RAMP_STOP))
    else $error("ramp stop flag wrong");
  AST_QSTOP_FLAG: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    quick_stop_active_o == (state_q == DSS_QUICK_STOP))
    else $error("quick stop flag wrong");
  AST_COAST_FLAG: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    coast_stop_active_o == (state_q == DSS_COAST_STOP))
    else $error("coast flag wrong");
  AST_FAULT_FLAG: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    fault_latched_o == (state_q == DSS_FAULT))
    else $error("fault flag wrong");
  AST_STOP_FLAGS_ONEHOT: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    $onehot0({ramp_stop_o, quick_stop_active_o, coast_stop_active_o, fault_latched_o}))
    else $error("several stop flags at once");

  // Main scenarios
  COV_HOLD: cover property (@(posedge clock_i) ramp_hold_o);
  COV_RUN: cover property (@(posedge clock_i) state_q == DSS_RDY_REF);
  COV_RAMP_STOP: cover property (@(posedge clock_i)
    state_q == DSS_RAMP_STOP ##1 state_q == DSS_OFF);
  COV_QSTOP: cover property (@(posedge clock_i)
    state_q == DSS_QUICK_STOP ##1 state_q == DSS_ON_INHIBIT);
  COV_FAULT_OUT: cover property (@(posedge clock_i)
    state_q == DSS_FAULT ##1 state_q == DSS_ON_INHIBIT);
endmodule

// ===== src/dss_pkg.sv
package dss_pkg;
  // Command-word bit positions
  localparam int unsigned CW_ON_BIT = 0;
  localparam int unsigned CW_NO_COAST_BIT = 1;
  localparam int unsigned CW_NO_QSTOP_BIT = 2;
  localparam int unsigned CW_RUN_BIT = 3;
  localparam int unsigned CW_RAMP_OUT_BIT = 4;
  localparam int unsigned CW_RAMP_ACC_BIT = 5;
  localparam int unsigned CW_RAMP_IN_BIT = 6;
  localparam int unsigned CW_RESET_BIT = 7;
  localparam int unsigned CW_REMOTE_BIT = 10;
  localparam int unsigned CW_NRAMP_START_BIT = 11;
  localparam int unsigned CW_WIDTH = 16;

  // Profile states; status output carries the encoding
  typedef enum logic [3:0] {
    DSS_ON_INHIBIT,
    DSS_OFF,
    DSS_RDY_ON,
    DSS_RDY_RUN,
    DSS_RDY_REF,
    DSS_RAMP_STOP,
    DSS_COAST_STOP,
    DSS_QUICK_STOP,
    DSS_FAULT
  } dss_state_t;

  localparam dss_state_t DSS_RESET_STATE = DSS_ON_INHIBIT;
  localparam logic [3:0] DSS_STATE_RESET_CODE = 4'h0;
endpackage

// ===== sim/dss_ctrl_model.sv
module dss_ctrl_model (
  input wire logic on_i, // On request
  input wire logic coast_i, // Coast stop request
  input wire logic quick_i, // Quick stop request
  input wire logic run_i, // Run permit
  input wire logic [2:0] ramp_i, // Ramp input, accel, output enables
  input wire logic reset_i, // Fault reset level
  input wire logic remote_i, // Remote permission
  input wire logic nramp_i, // Start by normal ramp
  output logic [15:0] cw_o // Command word block
);
  timeunit 1ns;
  timeprecision 1ps;
  // Stops are sent inverted, so an idle word of zeros reads as a stop
  assign cw_o = {4'h0, nramp_i, remote_i, 2'h0, reset_i, ramp_i, run_i,
                 ~quick_i, ~coast_i, on_i};
endmodule

// ===== sim/test_drive_state_sequencer.sv
module test_drive_state_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic on = 1'b1, cs = 1'b0, qs = 1'b0, run = 1'b0, rs = 1'b0, rem = 1'b1, nr = 1'b0;
  logic fault = 1'b0, rdy = 1'b0, zs = 1'b0;
  logic [2:0] rmp = 3'h7;
  logic [15:0] cw;
  logic [3:0] st;
  logic flux, pls, cen, trk, clmp, hld, irel, rstp, qsa, csa, flt;
  int miscompares = 0, num_checks = 0, cycles = 0;

  dss_ctrl_model u_ctrl (.on_i(on), .coast_i(cs), .quick_i(qs), .run_i(run), .ramp_i(rmp),
    .reset_i(rs), .remote_i(rem), .nramp_i(nr), .cw_o(cw));
  dss_sequencer u_dut (.clock_i(clock_i), .rst_b_i(rst_b_i), .cw_i(cw), .fault_i(fault),
    .ctrl_ready_i(rdy), .zero_speed_i(zs), .state_o(st), .flux_en_o(flux), .pulses_en_o(pls),
    .ctrl_en_o(cen), .ref_track_o(trk), .ramp_clamp_o(clmp), .ramp_hold_o(hld),
    .ramp_in_rel_o(irel), .ramp_stop_o(rstp), .quick_stop_active_o(qsa),
    .coast_stop_active_o(csa), .fault_latched_o(flt));

  // Free running clock, 8 ns period
  initial forever #4 clock_i = ~clock_i;

  // A hung sequence is cut short well after the roughly 55 cycles needed
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 2000) begin
      miscompares++;
      complete_run();
    end
  end

  task automatic chk(input string n, input logic [3:0] s, input logic [3:0] e);
    num_checks++;
    if (s !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask

  // One edge passes, inputs then change at the falling edge
  task automatic t(input logic [3:0] e);
    @(negedge clock_i);
    chk("state", st, e);
  endtask

  // From inhibit up to operation enabled
  task automatic up();
    on = 1'b0;
    t(4'h1);
    t(4'h2);
    on = 1'b1;
    run = 1'b1;
    t(4'h3);
    t(4'h4);
  endtask

  task automatic complete_run();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    repeat (16) @(negedge clock_i);
    rst_b_i = 1'b1;
    t(4'h0);
    chk("clamp", clmp, 4'h1);
    t(4'h0);
    on = 1'b0;
    rem = 1'b0;
    t(4'h1);
    t(4'h1);
    rem = 1'b1;
    t(4'h2);
    chk("flux_pulses", {flux, pls}, 4'h2);
    on = 1'b1;
    run = 1'b1;
    t(4'h3);
    chk("ctrl_en", cen, 4'h1);
    t(4'h3);
    rdy = 1'b1;
    t(4'h4);
    chk("track_pulses", {trk, pls}, 4'h3);
    chk("ramp", {clmp, hld, irel}, 4'h1);
    rmp = 3'h0;
    t(4'h4);
    chk("ctrl_ramp", {cen, clmp, hld, irel}, 4'hC);
    rmp = 3'h1;
    t(4'h4);
    chk("hold", {clmp, hld, irel}, 4'h2);
    run = 1'b0;
    t(4'h2);
    run = 1'b1;
    t(4'h3);
    t(4'h4);
    // All three stops at once: coast must win
    on = 1'b0;
    cs = 1'b1;
    qs = 1'b1;
    t(4'h6);
    chk("coast", csa, 4'h1);
    t(4'h0);
    cs = 1'b0;
    qs = 1'b0;
    up();
    on = 1'b0;
    t(4'h5);
    chk("ramp_stop", rstp, 4'h1);
    t(4'h5);
    zs = 1'b1;
    t(4'h1);
    zs = 1'b0;
    t(4'h2);
    nr = 1'b1;
    t(4'h3);
    t(4'h4);
    nr = 1'b0;
    t(4'h5);
    zs = 1'b1;
    t(4'h1);
    zs = 1'b0;
    t(4'h2);
    on = 1'b1;
    t(4'h3);
    t(4'h4);
    qs = 1'b1;
    t(4'h7);
    chk("quick", qsa, 4'h1);
    zs = 1'b1;
    t(4'h0);
    zs = 1'b0;
    qs = 1'b0;
    up();
    fault = 1'b1;
    t(4'h8);
    chk("fault", flt, 4'h1);
    fault = 1'b0;
    t(4'h8);
    rs = 1'b1;
    t(4'h0);
    complete_run();
  end
endmodule
